// [logic/asp_serial_port.v]
// Purpose: Asynchronous serial port with APB registers and four requests.
// Assumes: One 40 MHz clock; serial clock pin sampled as a plain input.
// Notes:   APB answers with one wait state; all outputs are registered.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "asp_map.vh"
module asp_serial_port (
  // Clock and reset.
  input  wire        clk,
  input  wire        resetn,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // Serial pins.
  input  wire        rxd,
  output reg         txd,
  input  wire        sck_i,
  output reg         sck_o,
  output reg         sck_oe,
  // Requests.
  output reg         tx_empty_irq,
  output reg         rx_full_irq,
  output reg         rx_error_irq,
  output reg         tx_end_irq,
  output reg         irq
);
  localparam S_IDLE  = 3'h0;
  localparam S_START = 3'h1;
  localparam S_DATA  = 3'h2;
  localparam S_PAR   = 3'h3;
  localparam S_STOP  = 3'h4;

  reg  [7:0] mode_q;
  reg  [7:0] brr_q;
  reg  [7:0] ctrl_q;
  reg  [7:0] stat_q;
  reg  [7:0] stat_d;
  reg  [7:0] ien_q;
  reg  [7:0] tdr_q;
  reg  [7:0] rdr_q;
  reg  [5:0] pre_q;
  reg  [7:0] bcnt_q;
  reg        sck_p_q;
  reg  [2:0] tx_st_q;
  reg  [3:0] tx_sub_q;
  reg  [2:0] tx_idx_q;
  reg  [7:0] tx_sh_q;
  reg  [2:0] rx_st_q;
  reg  [3:0] rx_sub_q;
  reg  [2:0] rx_idx_q;
  reg  [7:0] rx_sh_q;
  reg        rx_par_q;
  reg        rx_p_q;
  reg  [5:0] pre_mask;
  reg  [31:0] rd_word;
  reg        hit;

  wire       rx_s;
  wire       sck_s;
  wire       seven   = mode_q[`ASP_MODE_SEVEN];
  wire       par_en  = mode_q[`ASP_MODE_PAR];
  wire       odd     = mode_q[`ASP_MODE_ODD];
  wire       msb     = mode_q[`ASP_MODE_MSB];
  wire       tx_en   = ctrl_q[`ASP_CTRL_TXEN];
  wire       rx_en   = ctrl_q[`ASP_CTRL_RXEN];
  wire [1:0] cke     = ctrl_q[`ASP_CTRL_CKE_H:`ASP_CTRL_CKE_L];
  wire       ext_clk = cke[`ASP_CKE_EXT];
  wire [2:0] last_ix = seven ? `ASP_IDX_LAST7 : `ASP_IDX_LAST8;
  wire [7:0] dmask   = seven ? `ASP_MASK7 : 8'hFF;

  // Bus handshake: the access is completed on the edge that sees pready.
  wire acc   = psel & penable & pready;
  wire wr    = acc & pwrite;
  wire rd    = acc & ~pwrite;
  wire wr_td = wr & (paddr == `ASP_TDATA_OFS);
  wire wr_cl = wr & (paddr == `ASP_CLR_OFS);
  wire rd_rd = rd & (paddr == `ASP_RDATA_OFS);

  // Pin synchronisers for the receive line and the external clock.
  asp_sync u_rx_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin_i  (rxd),
    .sync_o (rx_s)
  );

  asp_sync u_sck_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin_i  (sck_i),
    .sync_o (sck_s)
  );

  // Prescaler selection of peripheral clock divided by 1, 4, 16 or 64.
  always @* begin
    case (mode_q[`ASP_MODE_CKS_H:`ASP_MODE_CKS_L])
      2'h0:    pre_mask = `ASP_PRE_D1;
      2'h1:    pre_mask = `ASP_PRE_D4;
      2'h2:    pre_mask = `ASP_PRE_D16;
      default: pre_mask = `ASP_PRE_D64;
    endcase
  end

  wire pre_tick  = ((pre_q & pre_mask) == pre_mask);
  wire half_tick = pre_tick & (bcnt_q == brr_q);
  // The generator runs at twice the 16x rate so the clock pin gets a
  // square wave; the 16x tick is taken on its rising half.
  wire int_tick  = half_tick & ~sck_o;
  wire ext_tick  = sck_s & ~sck_p_q;
  wire tick16    = ext_clk ? ext_tick : int_tick;

  // Baud generator. Bit rate is clk / (div * (brr + 1) * 32); external
  // mode caps at a quarter of clk per 16x edge due to the synchroniser.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q   <= 6'h00;
      bcnt_q  <= `ASP_ZERO8;
      sck_o   <= 1'b0;
      sck_oe  <= 1'b0;
      sck_p_q <= 1'b1; // Same as the synchroniser, so no false edge.
    end else begin
      pre_q   <= pre_q + 6'h01;
      sck_p_q <= sck_s;
      sck_oe  <= ~ext_clk & (cke == `ASP_CKE_OUT);
      if (pre_tick) begin
        bcnt_q <= half_tick ? `ASP_ZERO8 : bcnt_q + 8'h01;
      end
      if (half_tick) begin
        sck_o <= ~sck_o;
      end
    end
  end

  // Transmit bit selection honours length and bit order.
  wire [2:0] tx_pos = msb ? (last_ix - tx_idx_q) : tx_idx_q;
  wire       tx_par = ^(tx_sh_q & dmask) ^ odd;
  wire       tx_bit_end = tick16 & (tx_sub_q == `ASP_OVS_LAST);
  wire       tx_empty = stat_q[`ASP_ST_TXE];
  // Loading takes the buffer byte and frees the buffer for the next one.
  wire       tx_load = tx_en & ~tx_empty & tick16 &
                       ((tx_st_q == S_IDLE) ||
                        ((tx_st_q == S_STOP) && tx_bit_end));
  wire       tx_done = tx_en & (tx_st_q == S_STOP) & tx_bit_end & tx_empty;

  // Transmitter; independent of the receiver below.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_st_q  <= S_IDLE;
      tx_sub_q <= 4'h0;
      tx_idx_q <= 3'h0;
      tx_sh_q  <= `ASP_ZERO8;
      txd      <= 1'b1;
    end else if (!tx_en) begin
      tx_st_q  <= S_IDLE;
      txd      <= 1'b1;
    end else if (tx_load) begin
      tx_sh_q  <= tdr_q;
      tx_idx_q <= 3'h0; // A stale index would pick the wrong first bit.
      tx_st_q  <= S_START;
      tx_sub_q <= 4'h0;
      txd      <= 1'b0;
    end else if (tick16) begin
      tx_sub_q <= tx_sub_q + 4'h1;
      if (tx_bit_end) begin
        case (tx_st_q)
          S_START: begin
            tx_st_q  <= S_DATA;
            tx_idx_q <= 3'h0;
            txd      <= tx_sh_q[tx_pos];
          end
          S_DATA: begin
            if (tx_idx_q == last_ix) begin
              tx_st_q <= par_en ? S_PAR : S_STOP;
              txd     <= par_en ? tx_par : 1'b1;
            end else begin
              tx_idx_q <= tx_idx_q + 3'h1;
              txd      <= tx_sh_q[msb ? (last_ix - tx_idx_q - 3'h1)
                                      : (tx_idx_q + 3'h1)];
            end
          end
          S_PAR: begin
            tx_st_q <= S_STOP;
            txd     <= 1'b1;
          end
          S_STOP: begin
            tx_st_q <= S_IDLE;
            txd     <= 1'b1;
          end
          default: begin
            tx_st_q <= S_IDLE;
            txd     <= 1'b1;
          end
        endcase
      end
    end
  end

  // Receiver sampling: start confirmed at mid bit, then every 16 ticks.
  wire       rx_mid  = tick16 & (rx_sub_q == `ASP_OVS_MID);
  wire       rx_smp  = tick16 & (rx_sub_q == `ASP_OVS_LAST);
  wire [2:0] rx_pos  = msb ? (last_ix - rx_idx_q) : rx_idx_q;
  wire       rx_done = rx_en & (rx_st_q == S_STOP) & rx_smp;
  wire       rx_fer  = ~rx_s;
  wire       rx_per  = par_en & (rx_par_q != (^(rx_sh_q & dmask) ^ odd));
  wire       rx_brk  = rx_fer & ((rx_sh_q & dmask) == `ASP_ZERO8) &
                       ~(par_en & rx_par_q);
  wire       rx_ovr  = rx_done & stat_q[`ASP_ST_RDRF];

  // Receiver state machine.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_st_q  <= S_IDLE;
      rx_sub_q <= 4'h0;
      rx_idx_q <= 3'h0;
      rx_sh_q  <= `ASP_ZERO8;
      rx_par_q <= 1'b0;
      rx_p_q   <= 1'b1;
    end else if (!rx_en) begin
      rx_st_q  <= S_IDLE;
      rx_p_q   <= 1'b1;
    end else if (tick16) begin
      rx_p_q   <= rx_s;
      rx_sub_q <= rx_sub_q + 4'h1;
      case (rx_st_q)
        S_IDLE: begin
          // A level that is already low starts a character only on the first tick after enable.
          if (rx_p_q & ~rx_s) begin
            rx_st_q  <= S_START;
            rx_sub_q <= 4'h1;
            rx_sh_q  <= `ASP_ZERO8;
          end
        end
        S_START: begin
          if (rx_mid) begin
            rx_sub_q <= 4'h0;
            rx_idx_q <= 3'h0;
            rx_st_q  <= rx_s ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (rx_smp) begin
            rx_sh_q[rx_pos] <= rx_s;
            rx_idx_q <= rx_idx_q + 3'h1;
            if (rx_idx_q == last_ix) begin
              rx_st_q <= par_en ? S_PAR : S_STOP;
            end
          end
        end
        S_PAR: begin
          if (rx_smp) begin
            rx_par_q <= rx_s;
            rx_st_q  <= S_STOP;
          end
        end
        S_STOP: begin
          if (rx_smp) begin
            rx_st_q <= S_IDLE;
          end
        end
        default: rx_st_q <= S_IDLE;
      endcase
    end
  end

  // Status flags: hardware sets win over software clears in one cycle.
  always @* begin
    stat_d = stat_q;
    if (wr_cl) begin
      stat_d = stat_q & ~pwdata[7:0];
    end
    if (wr_td) begin
      stat_d[`ASP_ST_TXE] = 1'b0;
      stat_d[`ASP_ST_TXC] = 1'b0;
    end
    if (rd_rd) begin
      stat_d[`ASP_ST_RDRF] = 1'b0;
    end
    if (tx_load) begin
      stat_d[`ASP_ST_TXE] = 1'b1;
    end
    if (tx_done) begin
      stat_d[`ASP_ST_TXC] = 1'b1;
    end
    if (rx_done) begin
      if (rx_ovr) begin
        stat_d[`ASP_ST_ORER] = 1'b1;
      end else begin
        stat_d[`ASP_ST_RDRF] = 1'b1;
      end
      if (rx_fer) begin
        stat_d[`ASP_ST_FER] = 1'b1;
      end
      if (rx_per) begin
        stat_d[`ASP_ST_PER] = 1'b1;
      end
      if (rx_brk) begin
        stat_d[`ASP_ST_BRK] = 1'b1;
      end
    end
  end

  // Register writes and the received byte buffer.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= `ASP_ZERO8;
      brr_q  <= `ASP_BRR_RST;
      ctrl_q <= `ASP_ZERO8;
      ien_q  <= `ASP_ZERO8;
      tdr_q  <= `ASP_ZERO8;
      rdr_q  <= `ASP_ZERO8;
      stat_q <= `ASP_STAT_RST;
    end else begin
      stat_q <= stat_d;
      if (wr && paddr == `ASP_MODE_OFS) mode_q <= pwdata[7:0];
      if (wr && paddr == `ASP_BRR_OFS)  brr_q  <= pwdata[7:0];
      if (wr && paddr == `ASP_CTRL_OFS) ctrl_q <= pwdata[7:0];
      if (wr && paddr == `ASP_IEN_OFS)  ien_q  <= pwdata[7:0];
      if (wr_td) begin
        tdr_q <= pwdata[7:0];
      end
      // An overrun keeps the unread byte; the new one is dropped.
      if (rx_done && !rx_ovr) begin
        rdr_q <= rx_sh_q & dmask;
      end
    end
  end

  // Read multiplexer and address decode.
  always @* begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      `ASP_MODE_OFS:  rd_word[7:0] = mode_q;
      `ASP_BRR_OFS:   rd_word[7:0] = brr_q;
      `ASP_CTRL_OFS:  rd_word[7:0] = ctrl_q;
      `ASP_STAT_OFS:  rd_word[7:0] = stat_q;
      `ASP_CLR_OFS:   rd_word[7:0] = `ASP_ZERO8;
      `ASP_IEN_OFS:   rd_word[7:0] = ien_q;
      `ASP_TDATA_OFS: rd_word[7:0] = tdr_q;
      `ASP_RDATA_OFS: rd_word[7:0] = rdr_q;
      default:        hit = 1'b0;
    endcase
  end

  // APB answer: one wait state so read data comes from a flip-flop.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr <= ~hit;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Interrupt requests, registered from status and enable.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_empty_irq <= 1'b0;
      rx_full_irq  <= 1'b0;
      rx_error_irq <= 1'b0;
      tx_end_irq   <= 1'b0;
      irq          <= 1'b0;
    end else begin
      tx_empty_irq <= stat_q[`ASP_ST_TXE] & ien_q[`ASP_ST_TXE];
      rx_full_irq  <= stat_q[`ASP_ST_RDRF] & ien_q[`ASP_ST_RDRF];
      rx_error_irq <= |(stat_q & ien_q & `ASP_ERR_MASK);
      tx_end_irq   <= stat_q[`ASP_ST_TXC] & ien_q[`ASP_ST_TXC];
      irq          <= |(stat_q & ien_q);
    end
  end
endmodule
`default_nettype wire

// [logic/asp_map.vh]
// Purpose: Constants of the asynchronous serial port: offsets, fields, counts.
// Assumes: APB with 32-bit data, one aligned word for each register.
// Notes:   Included by the port and its testbench; definitions only.
// Operation
// - Each character has start and stop bit; timing restarts per char.
// - Transmitter and receiver run independently and at the same time.
// - Both directions double buffered so characters follow back to back.
// - An idle transmitter holds the line high.
// - Receiver starts a character on a high to low line transition.
// - Order is start low, data LSB or MSB first, optional parity, stop high.
// - Data length is seven or eight bits.
// - Bit order is selectable, LSB first or MSB first.
// - Internal source is peripheral clock divided by 1, 4, 16 or 64.
// - Internal generator clocks the port; may output 16x clock pin.
// - External source bypasses generator; far end gives 16x clock.
// - Internal source reaches 110 up to 1562500 bit/s at 50 MHz.
// - External 12.5 MHz clock reaches up to 781250 bit/s.
// - Receiver detects framing, parity, overrun errors and breaks.
// - Four requests: tx empty, rx full, rx error, tx end.
// - After reset tx empty and tx end flags set, status reads 0x84.
// - Tx irq enable gates tx empty request; tx enable gates sending.
`ifndef ASP_MAP_VH
`define ASP_MAP_VH

// Register byte offsets.
`define ASP_MODE_OFS   8'h00
`define ASP_BRR_OFS    8'h04
`define ASP_CTRL_OFS   8'h08
`define ASP_STAT_OFS   8'h0C
`define ASP_CLR_OFS    8'h10
`define ASP_IEN_OFS    8'h14
`define ASP_TDATA_OFS  8'h18
`define ASP_RDATA_OFS  8'h1C

// Mode fields.
`define ASP_MODE_SEVEN 0
`define ASP_MODE_PAR   1
`define ASP_MODE_ODD   2
`define ASP_MODE_MSB   3
`define ASP_MODE_CKS_L 4
`define ASP_MODE_CKS_H 5

// Control fields.
`define ASP_CTRL_CKE_L 0
`define ASP_CTRL_CKE_H 1
`define ASP_CTRL_RXEN  4
`define ASP_CTRL_TXEN  5
`define ASP_CKE_OUT    2'h1
`define ASP_CKE_EXT    1

// Status, clear and enable fields.
`define ASP_ST_BRK     1
`define ASP_ST_TXC     2
`define ASP_ST_PER     3
`define ASP_ST_FER     4
`define ASP_ST_ORER    5
`define ASP_ST_RDRF    6
`define ASP_ST_TXE     7

// Receive error flags: overrun, framing, parity and break, not tx end.
`define ASP_ERR_MASK   8'h3A

// Reset values.
`define ASP_STAT_RST   8'h84
`define ASP_BRR_RST    8'hFF
`define ASP_ZERO8      8'h00

// Prescaler masks for divide by 1, 4, 16 and 64.
`define ASP_PRE_D1     6'h00
`define ASP_PRE_D4     6'h03
`define ASP_PRE_D16    6'h0F
`define ASP_PRE_D64    6'h3F

// Oversampling counts: sixteen ticks per bit, middle at the eighth.
`define ASP_OVS_LAST   4'hF
`define ASP_OVS_MID    4'h7
`define ASP_IDX_LAST8  3'h7
`define ASP_IDX_LAST7  3'h6
`define ASP_MASK7      8'h7F

`endif

// [logic/asp_sync.v]
// Purpose: Two-stage synchroniser for one asynchronous pin.
// Assumes: Pin level changes slower than the clock.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/1ps
`default_nettype none
module asp_sync (
  // Clock and reset.
  input  wire clk,
  input  wire resetn,
  // Pin in, synchronised level out.
  input  wire pin_i,
  output wire sync_o
);
  reg meta_q;
  reg sync_q;

  // Both stages reset high, the idle level of every pin that uses this.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule
`default_nettype wire

// [tb/asp_serial_port_checker.sv]
// Purpose: Port-level checks of the asynchronous serial port.
// Assumes: Bound to the top module; one clock domain.
// Notes:   The bit floor is 32 clocks, the fastest rate setting.
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port_checker (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        resetn,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Serial line and requests.
  input wire logic        txd,
  input wire logic        tx_empty_irq,
  input wire logic        rx_full_irq,
  input wire logic        rx_error_irq,
  input wire logic        tx_end_irq,
  input wire logic        irq
);
  logic [7:0] run_q;
  logic [1:0] age_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Cycles since txd last moved and since reset; both saturate.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_q <= 8'h00;
      age_q <= 2'h0;
    end else begin
      run_q <= $changed(txd) ? 8'h00 : run_q + {7'h00, run_q != 8'hFF};
      age_q <= age_q + {1'b0, age_q != 2'h3};
    end
  end

  chk_apb_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_cause: assert property (pready |-> psel && $past(penable))
    else $error("pready without access phase");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_rdata_high: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_irq_any: assert property (
    irq == (tx_empty_irq | rx_full_irq | rx_error_irq | tx_end_irq))
    else $error("irq does not match requests");
  chk_bit_floor: assert property ($changed(txd) |-> run_q >= 8'h1F)
    else $error("txd level shorter than one bit");
  chk_idle_reset: assert property (age_q != 2'h3 |-> txd)
    else $error("txd low right after reset");

  cover property ($fell(txd));
  cover property ($rose(rx_full_irq));
  cover property ($rose(rx_error_irq));
  cover property (pslverr);
endmodule
bind asp_serial_port asp_serial_port_checker u_asp_serial_port_checker (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .txd(txd), .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq),
  .rx_error_irq(rx_error_irq), .tx_end_irq(tx_end_irq), .irq(irq));
`default_nettype wire

// [tb/asp_remote_node.sv]
// Purpose: Remote asynchronous node facing the serial pins of the port.
// Assumes: Both ends run at bit_clk clocks per bit.
// Notes:   Sends whole frames from the bench and decodes every frame.
`timescale 1ns/1ps
`default_nettype none
module asp_remote_node (
  // Clock.
  input  wire logic clk,
  // Serial lines.
  output var  logic rxd,
  input  wire logic txd
);
  int          bit_clk = 32;
  int          rx_bits = 9;
  logic [15:0] got_q[$];

  // The line idles at the mark level between frames.
  initial rxd = 1'b1;

  // Low start bit, then n slots of f, first slot first.
  task automatic send(input logic [15:0] f, input int n);
    int k;
    @(posedge clk);
    rxd <= 1'b0;
    repeat (bit_clk) @(posedge clk);
    for (k = 0; k < n; k++) begin
      rxd <= f[k];
      repeat (bit_clk) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (2 * bit_clk) @(posedge clk);
  endtask

  // Samples mid-bit after each start edge; stop slot kept for checking.
  always begin : rx_proc
    logic [15:0] v;
    int          k;
    v = 16'h0000;
    @(negedge txd);
    repeat (bit_clk / 2) @(posedge clk);
    for (k = 0; k < rx_bits; k++) begin
      repeat (bit_clk) @(posedge clk);
      v[k] = txd;
    end
    got_q.push_back(v);
  end
endmodule
`default_nettype wire

// [tb/asp_serial_port_tb.sv]
// Purpose: Self-checking bench of the asynchronous serial port.
// Assumes: 40 MHz clock; remote node at 32 clocks per bit.
// Notes:   Prescaler test runs last since its frames go undecoded.
`timescale 1ns/1ps
`default_nettype none
`include "asp_map.vh"
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin \
  fails++; $display("[FAIL] %0t %s: %h/%h", $time, m, g, e); end end
module asp_serial_port_tb;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        sck_i = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] r, prdata;
  logic        e, pready, pslverr, rxd, txd, sck_o, sck_oe, irq;
  logic        txe_irq, rf_irq, re_irq, tn_irq;
  logic [2:0]  sck_n = 3'h0;
  logic [7:0]  modes [5] = '{8'h00, 8'h01, 8'h08, 8'h02, 8'h06};
  int          fails = 0;
  int          checks_done = 0;
  int          n, i, m;

  asp_serial_port u_asp_serial_port (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .rxd(rxd), .txd(txd),
    .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .tx_empty_irq(txe_irq),
    .rx_full_irq(rf_irq), .rx_error_irq(re_irq), .tx_end_irq(tn_irq),
    .irq(irq));
  asp_remote_node u_asp_remote_node (.clk(clk), .rxd(rxd), .txd(txd));

  // 25 ns clock; the far end's 16x clock runs at one eighth of it.
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    sck_n <= sck_n + 3'h1;
    sck_i <= sck_n[2];
  end

  // One APB transfer; waits for pready with a bound.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) fails++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls status until a flag of the mask is set.
  task automatic wait_stat(input logic [7:0] m);
    int k;
    k = 0;
    do begin apb(1'b0, `ASP_STAT_OFS, 32'h0); k++; end
      while ((r[7:0] & m) === 8'h00 && k < 9000);
    if (k >= 9000) fails++;
  endtask

  // Expected line slots after the start bit, stop bit included.
  function automatic logic [15:0] frame(input logic [7:0] d, input logic [7:0] m);
    logic [15:0] f;
    int          c, k;
    c = m[0] ? 7 : 8;
    f = 16'h0000;
    for (k = 0; k < c; k++) f[k] = m[3] ? d[c - 1 - k] : d[k];
    if (m[1]) f[c] = ^(d & (m[0] ? 8'h7F : 8'hFF)) ^ m[2];
    f[c + m[1]] = 1'b1;
    return f;
  endfunction
  function automatic int nb(input logic [7:0] m);
    return (m[0] ? 7 : 8) + m[1] + 1;
  endfunction

  // One receive error case: request, flags, then clearing.
  task automatic err_case(input logic [7:0] m, input logic [15:0] f,
                          input int c, input int reps, input logic [7:0] x);
    apb(1'b1, `ASP_MODE_OFS, {24'h0, m});
    repeat (reps) u_asp_remote_node.send(f, c);
    `CHK(re_irq, 1'b1, "error request")
    apb(1'b0, `ASP_STAT_OFS, 32'h0);
    `CHK(r[7:0] & 8'h3A, x, "error flags")
    apb(1'b1, `ASP_CLR_OFS, 32'h7A);
    repeat (2) @(posedge clk);
    `CHK(re_irq, 1'b0, "error cleared")
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog well past the expected run of about 35k cycles.
  initial begin
    repeat (95000) @(posedge clk);
    fails++;
    test_done;
  end

  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, `ASP_STAT_OFS, 32'h0);
    `CHK(r[7:0], `ASP_STAT_RST, "status reset")
    apb(1'b0, `ASP_BRR_OFS, 32'h0);
    `CHK(r[7:0], `ASP_BRR_RST, "rate reset")
    apb(1'b0, 8'h40, 32'h0);
    `CHK({e, r}, {1'b1, 32'h0}, "unmapped read")
    $display("test reset done");
    apb(1'b1, `ASP_BRR_OFS, 32'h0);
    apb(1'b1, `ASP_CTRL_OFS, 32'h30);
    apb(1'b1, `ASP_IEN_OFS, 32'h40);
    for (i = 0; i < 5; i++) begin
      apb(1'b1, `ASP_MODE_OFS, {24'h0, modes[i]});
      u_asp_remote_node.rx_bits = nb(modes[i]);
      u_asp_remote_node.got_q.delete();
      apb(1'b1, `ASP_TDATA_OFS, 32'hA5);
      wait_stat(8'h80);
      apb(1'b1, `ASP_TDATA_OFS, 32'h3C);
      u_asp_remote_node.send(frame(8'hDA, modes[i]), nb(modes[i]));
      n = 0;
      while (u_asp_remote_node.got_q.size() < 2 && n < 3000) begin
        @(posedge clk);
        n++;
      end
      `CHK(u_asp_remote_node.got_q[0], frame(8'hA5, modes[i]), "tx 1")
      `CHK(u_asp_remote_node.got_q[1], frame(8'h3C, modes[i]), "tx 2")
      `CHK(rf_irq, 1'b1, "rx full")
      apb(1'b0, `ASP_RDATA_OFS, 32'h0);
      `CHK(r[7:0], modes[i][0] ? 8'h5A : 8'hDA, "rx data")
    end
    $display("test modes done");
    apb(1'b1, `ASP_CLR_OFS, 32'h7A);
    apb(1'b1, `ASP_IEN_OFS, 32'h3A);
    err_case(8'h00, frame(8'h55, 8'h00) & 16'h00FF, 9, 1, 8'h10);
    err_case(8'h00, 16'h0000, 9, 1, 8'h12);
    err_case(8'h02, frame(8'h01, 8'h02) ^ 16'h0100, 10, 1, 8'h08);
    err_case(8'h00, frame(8'h33, 8'h00), 9, 2, 8'h20);
    $display("test errors done");
    apb(1'b1, `ASP_CTRL_OFS, 32'h10);
    apb(1'b1, `ASP_IEN_OFS, 32'h80);
    repeat (2) @(posedge clk);
    `CHK(txe_irq, 1'b1, "tx empty request")
    apb(1'b1, `ASP_TDATA_OFS, 32'h81);
    repeat (2) @(posedge clk);
    `CHK(txe_irq, 1'b0, "tx empty drops")
    n = 0;
    repeat (200) begin @(posedge clk); if (txd !== 1'b1) n++; end
    `CHK(n, 0, "tx disabled")
    apb(1'b1, `ASP_IEN_OFS, 32'h84);
    apb(1'b1, `ASP_CTRL_OFS, 32'h30);
    wait_stat(8'h04);
    repeat (2) @(posedge clk);
    `CHK({txe_irq, tn_irq, irq, re_irq}, 4'hE, "tx requests")
    apb(1'b1, `ASP_IEN_OFS, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0, "masked")
    $display("test requests done");
    for (i = 0; i < 5; i++) begin
      apb(1'b1, `ASP_MODE_OFS, {26'h0, i[1:0] & {2{i < 4}}, 4'h0});
      apb(1'b1, `ASP_CTRL_OFS, (i < 4) ? 32'h21 : 32'h22);
      repeat (2) @(posedge clk);
      `CHK(sck_oe, i < 4, "clock pin drive")
      apb(1'b1, `ASP_TDATA_OFS, 32'hFF);
      n = 0;
      while (txd !== 1'b0 && n < 3000) begin @(posedge clk); n++; end
      n = 0;
      m = 0;
      while (txd === 1'b0 && n < 3000) begin
        @(posedge clk);
        n++;
        m += int'(sck_o === 1'b1);
      end
      `CHK(n, (i < 4) ? (32 << (2 * i)) : 128, "bit length")
      `CHK(m, (i < 4) ? (16 << (2 * i)) : 64, "clock pin duty")
      wait_stat(8'h04);
    end
    $display("test clocks done");
    test_done;
  end
endmodule
`default_nettype wire
